/* File: lcr_regs.vh */
// Constants for the lane two and three control register bank
// Notes on behaviour
// - Polarity bit 0 set inverts that lane's receive data; resets to zero.
// - Bit 1 powers the lane down when set, normal when clear; resets zero.
// - Lane two sleep bit drives power-down vector index 2, lane three index 3.
// - Bit 2 is a read/write spare lane control bit resetting to one.
// - Lane three control word sits at byte offset 0x10, one word per lane.
// - First lane (lane two) control word sits at 0x0C, lanes spaced four bytes apart.
`ifndef LCR_REGS_VH
`define LCR_REGS_VH

`define LCR_ADDR_W        8
`define LCR_DATA_W        32
`define LCR_STRB_W        4
`define LCR_LANE_DATA_W   32
`define LCR_CTRL_W        3
`define LCR_LANE_CNT      2

`define LCR_OFFS_LANE_ONE   8'h08
`define LCR_OFFS_LANE_THREE 8'h10
`define LCR_LANE_STRIDE     8'h04
`define LCR_FIRST_LANE      2
`define LCR_BASE_LANE       1

`define LCR_BIT_INVERT  0
`define LCR_BIT_SLEEP   1
`define LCR_BIT_SPARE   2

`define LCR_RST_INVERT  1'b0
`define LCR_RST_SLEEP   1'b0
`define LCR_RST_SPARE   1'b1

`define LCR_PD_IDX_TWO    2
`define LCR_PD_IDX_THREE  3

`define LCR_WORD_ZERO   32'h0000_0000

`endif

/* File: lcr_lane_cell.v */
// One lane's control bits and its polarity-corrected receive stage
`timescale 1ns/10ps
`default_nettype none
`include "lcr_regs.vh"

module lcr_lane_cell (
  input  wire                          sys_clk,
  input  wire                          rst,
  input  wire                          wrEn,
  input  wire [`LCR_CTRL_W-1:0]        wrBits,
  output reg  [`LCR_CTRL_W-1:0]        ctrlBits,
  input  wire [`LCR_LANE_DATA_W-1:0]   rxData,
  input  wire                          rxValid,
  output reg  [`LCR_LANE_DATA_W-1:0]   rxDataOut,
  output reg                           rxValidOut
);

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrlBits[`LCR_BIT_INVERT] <= `LCR_RST_INVERT;
      ctrlBits[`LCR_BIT_SLEEP]  <= `LCR_RST_SLEEP;
      ctrlBits[`LCR_BIT_SPARE]  <= `LCR_RST_SPARE;
    end else if (wrEn) begin
      ctrlBits <= wrBits;
    end
  end

  // Every data bit flips when the lane's pair is swapped on the board
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rxDataOut  <= {`LCR_LANE_DATA_W{1'b0}};
      rxValidOut <= 1'b0;
    end else begin
      rxDataOut  <= rxData ^ {`LCR_LANE_DATA_W{ctrlBits[`LCR_BIT_INVERT]}};
      rxValidOut <= rxValid;
    end
  end

endmodule
`default_nettype wire

/* File: lcr_lane_ctrl.v */
// APB register bank and receive stage for lanes two and three
`timescale 1ns/10ps
`default_nettype none
`include "lcr_regs.vh"

module lcr_lane_ctrl (
  input  wire                          sys_clk,
  input  wire                          rst,
  input  wire                          psel,
  input  wire                          penable,
  input  wire                          pwrite,
  input  wire [`LCR_ADDR_W-1:0]        paddr,
  input  wire [`LCR_DATA_W-1:0]        pwdata,
  input  wire [`LCR_STRB_W-1:0]        pstrb,
  output reg                           pready,
  output reg  [`LCR_DATA_W-1:0]        prdata,
  output reg                           pslverr,
  input  wire [`LCR_LANE_DATA_W-1:0]   rxDataTwo,
  input  wire                          rxValidTwo,
  input  wire [`LCR_LANE_DATA_W-1:0]   rxDataThree,
  input  wire                          rxValidThree,
  output wire [`LCR_LANE_DATA_W-1:0]   rxFixedDataTwo,
  output wire                          rxFixedValidTwo,
  output wire [`LCR_LANE_DATA_W-1:0]   rxFixedDataThree,
  output wire                          rxFixedValidThree,
  output wire [`LCR_PD_IDX_THREE:`LCR_PD_IDX_TWO] lanePowerDown,
  output wire [`LCR_PD_IDX_THREE:`LCR_PD_IDX_TWO] laneSpare
);

  localparam [1:0] ST_IDLE   = 2'b01;
  localparam [1:0] ST_ANSWER = 2'b10;

  localparam LW = `LCR_LANE_DATA_W;
  localparam CW = `LCR_CTRL_W;
  localparam NL = `LCR_LANE_CNT;

  reg  [1:0]          state;
  reg  [1:0]          next_state;
  reg  [NL-1:0]       hitLatched;
  reg  [NL-1:0]       hitNow;
  reg  [`LCR_DATA_W-1:0] readWord;
  wire [NL*CW-1:0]    ctrlBus;
  wire [NL*LW-1:0]    rxInBus;
  wire [NL-1:0]       rxValidInBus;
  wire [NL*LW-1:0]    rxOutBus;
  wire [NL-1:0]       rxValidOutBus;
  wire                setupPhase;
  wire                accessDone;
  wire                writeTaken;
  integer             i;

  assign rxInBus      = {rxDataThree, rxDataTwo};
  assign rxValidInBus = {rxValidThree, rxValidTwo};

  assign setupPhase = psel && !penable;
  assign accessDone = (state == ST_ANSWER) && psel && penable && pready;
  // Only the low byte holds live bits, so its strobe gates the write
  assign writeTaken = accessDone && pwrite && pstrb[0];

  // Address decode: lane n lives at lane-one offset plus (n-1) words
  always @* begin
    hitNow = {NL{1'b0}};
    for (i = 0; i < NL; i = i + 1) begin
      if (paddr == `LCR_OFFS_LANE_ONE +
          (i[`LCR_ADDR_W-1:0] + `LCR_FIRST_LANE - `LCR_BASE_LANE) *
          `LCR_LANE_STRIDE) begin
        hitNow[i] = 1'b1;
      end
    end
  end

  // Read data assembled from the live control bits, upper bits zero
  always @* begin
    readWord = `LCR_WORD_ZERO;
    for (i = 0; i < NL; i = i + 1) begin
      if (hitNow[i]) begin
        readWord[CW-1:0] = ctrlBus[i*CW +: CW];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NL; g = g + 1) begin : gLane
      lcr_lane_cell uCell (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .wrEn       (writeTaken && hitLatched[g]),
        .wrBits     (pwdata[CW-1:0]),
        .ctrlBits   (ctrlBus[g*CW +: CW]),
        .rxData     (rxInBus[g*LW +: LW]),
        .rxValid    (rxValidInBus[g]),
        .rxDataOut  (rxOutBus[g*LW +: LW]),
        .rxValidOut (rxValidOutBus[g])
      );
      assign lanePowerDown[`LCR_PD_IDX_TWO + g] =
        ctrlBus[g*CW + `LCR_BIT_SLEEP];
      assign laneSpare[`LCR_PD_IDX_TWO + g] =
        ctrlBus[g*CW + `LCR_BIT_SPARE];
    end
  endgenerate

  assign rxFixedDataTwo    = rxOutBus[LW-1:0];
  assign rxFixedDataThree  = rxOutBus[2*LW-1:LW];
  assign rxFixedValidTwo   = rxValidOutBus[0];
  assign rxFixedValidThree = rxValidOutBus[1];

  always @* begin
    case (state)
      ST_IDLE: begin
        next_state = setupPhase ? ST_ANSWER : ST_IDLE;
      end
      ST_ANSWER: begin
        next_state = (accessDone || !psel) ? ST_IDLE : ST_ANSWER;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Answer is registered at the setup edge, so every access completes with no wait state
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state      <= ST_IDLE;
      hitLatched <= {NL{1'b0}};
      pready     <= 1'b0;
      prdata     <= `LCR_WORD_ZERO;
      pslverr    <= 1'b0;
    end else begin
      state <= next_state;
      case (state)
        ST_IDLE: begin
          if (setupPhase) begin
            hitLatched <= hitNow;
            pready     <= 1'b1;
            prdata     <= pwrite ? `LCR_WORD_ZERO : readWord;
            pslverr    <= ~|hitNow;
          end
        end
        ST_ANSWER: begin
          if (accessDone || !psel) begin
            hitLatched <= {NL{1'b0}};
            pready     <= 1'b0;
            pslverr    <= 1'b0;
          end
        end
        default: begin
          hitLatched <= {NL{1'b0}};
          pready     <= 1'b0;
          pslverr    <= 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

/* File: lcr_lane_ctrl_sva.sv */
// Port assertions for the lane two and three control bank
`timescale 1ns/10ps
`default_nettype none
module lcr_lane_ctrl_sva (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic [3:2]  lanePowerDown,
  input wire logic [3:2]  laneSpare
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire wrOk = psel && penable && pready && pwrite && pstrb[0];
  wire wrTwo = wrOk && paddr == 8'h0C;
  wire wrThree = wrOk && paddr == 8'h10;
  wire mapped = paddr == 8'h0C || paddr == 8'h10;
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_err_unmapped: assert property (pready && !mapped |-> pslverr)
    else $error("no error");
  a_ok_mapped: assert property (pready && mapped |-> !pslverr)
    else $error("false error");
  a_high_zero: assert property (pready |-> prdata[31:3] == 0)
    else $error("upper bits set");
  a_sleep_two: assert property (wrTwo |=> lanePowerDown[2] == $past(pwdata[1]))
    else $error("lane two sleep");
  a_sleep_three: assert property (wrThree |=> lanePowerDown[3] == $past(pwdata[1]))
    else $error("lane three sleep");
  a_spare_three: assert property (wrThree |=> laneSpare[3] == $past(pwdata[2]))
    else $error("lane three spare");
  a_sleep_hold: assert property (!(wrTwo || wrThree) |=> $stable(lanePowerDown))
    else $error("sleep changed");
endmodule
bind lcr_lane_ctrl lcr_lane_ctrl_sva i_lcr_lane_ctrl_sva (.*);
`default_nettype wire

/* File: lcr_lane_ctrl_bench.sv */
// Self-checking bench for the lane two and three control bank
`timescale 1ns/10ps
`default_nettype none
module lcr_lane_ctrl_bench;
  logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic        rxValidTwo, rxValidThree, rxFixedValidTwo, rxFixedValidThree;
  logic [7:0]  paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata, rxDataTwo, rxDataThree;
  logic [31:0] rxFixedDataTwo, rxFixedDataThree;
  logic [3:2]  lanePowerDown, laneSpare;
  int          n_errors, total_checks;
  lcr_lane_ctrl i_lcr_lane_ctrl (.*);
  initial begin
    sys_clk = 0;
    forever #10 sys_clk = ~sys_clk;
  end
  task chk(input logic [31:0] g, x);
    total_checks++;
    if (g !== x) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic [31:0] x, input logic xe);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk) penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    if (!w) chk(prdata, x);
    chk(32'(pslverr), 32'(xe));
    psel <= 0;
    penable <= 0;
    @(posedge sys_clk);
  endtask
  task t_reset;
    xfer(0, 8'h0C, 0, 32'h4, 0);
    xfer(0, 8'h10, 0, 32'h4, 0);
    chk(32'({lanePowerDown, laneSpare}), 32'h3);
    $display("reset test done");
  endtask
  task t_map;
    xfer(1, 8'h0C, 32'hFFFF_FFFF, 0, 0);
    xfer(0, 8'h0C, 0, 32'h7, 0);
    chk(32'(lanePowerDown), 32'h1);
    xfer(1, 8'h10, 32'h2, 0, 0);
    xfer(0, 8'h10, 0, 32'h2, 0);
    chk(32'({lanePowerDown, laneSpare}), 32'hD);
    $display("map test done");
  endtask
  task t_unmapped;
    xfer(1, 8'h08, 32'h5, 0, 1);
    xfer(0, 8'h08, 0, 0, 1);
    xfer(0, 8'h0C, 0, 32'h7, 0);
    pstrb <= 4'hE;
    xfer(1, 8'h0C, 32'h0, 0, 0);
    pstrb <= 4'hF;
    xfer(0, 8'h0C, 0, 32'h7, 0);
    $display("unmapped test done");
  endtask
  task t_invert;
    xfer(1, 8'h0C, 32'h1, 0, 0);
    rxDataTwo <= 32'h1234_5678;
    rxDataThree <= 32'h1234_5678;
    rxValidTwo <= 1;
    rxValidThree <= 1;
    repeat (2) @(posedge sys_clk);
    chk(rxFixedDataTwo, 32'hEDCB_A987);
    chk(rxFixedDataThree, 32'h1234_5678);
    chk(32'({rxFixedValidTwo, rxFixedValidThree}), 32'h3);
    $display("invert test done");
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, rxValidTwo, rxValidThree} = 0;
    {rxDataTwo, rxDataThree} = 0;
    pstrb = 4'hF;
    rst = 1;
    repeat (20) @(posedge sys_clk);
    rst <= 0;
    @(posedge sys_clk);
    t_reset;
    t_map;
    t_unmapped;
    t_invert;
    print_verdict;
  end
  initial begin
    #20000;
    n_errors++;
    print_verdict;
  end
endmodule
`default_nettype wire
